// >>> fpa_defines.vh
// Constants for the fixed-point arithmetic and move unit
`ifndef FPA_DEFINES_VH
`define FPA_DEFINES_VH
// ----------------------------------------------------------------------
// Register offsets on APB (byte addresses)
// ----------------------------------------------------------------------
`define FPA_OFF_INSTR 12'h000
`define FPA_OFF_CTRL 12'h004
`define FPA_OFF_STATUS 12'h008
`define FPA_OFF_RESULT 12'h00C
`define FPA_OFF_STORE 12'h010
`define FPA_OFF_LOAD 12'h014
`define FPA_OFF_OPA 12'h018
// ----------------------------------------------------------------------
// Instruction register field positions
// ----------------------------------------------------------------------
`define FPA_ARITH_LSB 0
`define FPA_MOV0_LSB 8
`define FPA_MOVE_SLOT1_LSB 14
`define FPA_MOVE_SLOT2_LSB 20
`define FPA_MOVE_SLOT3_LSB 26
`define FPA_FLD_W 6
// Arithmetic field: bit0 enable, bit1 mixed, bit2 neg outer, bit3 minus B,
// bit4 minus E, bit5 use B, bit6 use E, bit7 use C
`define FPA_CTRL_PAUSE_LSB 0
`define FPA_CTRL_NOP_BIT 3
// ----------------------------------------------------------------------
// Move source and destination codes
// ----------------------------------------------------------------------
`define FPA_R_A 4'h0
`define FPA_R_B 4'h1
`define FPA_R_C 4'h2
`define FPA_R_D 4'h3
`define FPA_R_E 4'h4
`define FPA_R_R 4'h5
`define FPA_R_S 4'h6
`define FPA_R_L 4'h7
`define FPA_R_T 4'h8
`define FPA_R_NONE 4'hF
// ----------------------------------------------------------------------
// Status bits and reset values
// ----------------------------------------------------------------------
`define FPA_ST_RANGE 15
`define FPA_ST_POS 14
`define FPA_ST_NEG 13
`define FPA_ST_CONFLICT 12
`define FPA_ST_ACTIVE 9
`define FPA_WORD_RST 16'h0000
`define FPA_INT_MAX 17'sh07FFF
`define FPA_PHASES 3'h4
`endif

// >>> fpa_unit.v
// Fixed-point arithmetic unit with internal move bus and APB registers
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fpa_defines.vh"

module fpa_unit (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [15:0] sys_bus_data,
  output reg [15:0] sys_bus_out,
  output wire busy
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_PAUSE = 2'b10;

  reg [1:0] state_q;
  reg [1:0] phase_q;
  reg tail_q;
  reg [2:0] pause_q;
  reg [31:0] instr_q;
  reg [3:0] ctrl_q;
  reg [15:0] op_a_q, op_b_q, op_c_q, op_d_q, op_e_q;
  reg [15:0] result_reg_q;
  reg [15:0] bus_store_reg_q;
  reg [15:0] move_data_q;
  reg [6:0] move_tidx_q;
  reg [32:0] product_buffer_q;
  reg pos_range_err_q, neg_range_err_q, range_err_q, conflict_q;
  reg [15:0] scratch_file [0:127];

  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign busy = (state_q != ST_IDLE);

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  // Move field: [2:0] source code, [5:3] destination code; one 6-bit field per slot
  function [5:0] slot_field;
    input [31:0] ins;
    input [1:0] slot;
    begin
      case (slot)
        2'd0: slot_field = ins[`FPA_MOV0_LSB +: `FPA_FLD_W];
        2'd1: slot_field = ins[`FPA_MOVE_SLOT1_LSB +: `FPA_FLD_W];
        2'd2: slot_field = ins[`FPA_MOVE_SLOT2_LSB +: `FPA_FLD_W];
        default: slot_field = ins[`FPA_MOVE_SLOT3_LSB +: `FPA_FLD_W];
      endcase
    end
  endfunction

  // Field bits [2:0] pick the source; [5:3] pick the destination, where
  // 3'h7 means scratch and the index is instr_q[30:24] XOR the slot's field.
  function [15:0] read_source;
    input [2:0] code;
    begin
      case (code)
        3'd0: read_source = op_a_q;
        3'd1: read_source = op_b_q;
        3'd2: read_source = op_c_q;
        3'd3: read_source = op_d_q;
        3'd4: read_source = op_e_q;
        3'd5: read_source = result_reg_q;
        3'd6: read_source = sys_bus_data; // Store reads the bus live
        default: read_source = scratch_file[move_tidx_q];
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Arithmetic datapath
  // --------------------------------------------------------------------
  wire [7:0] af = instr_q[`FPA_ARITH_LSB +: 8];
  wire [16:0] a_x = {op_a_q[15], op_a_q};
  wire [16:0] b_x = af[5] ? {op_b_q[15], op_b_q} : 17'h00000;
  wire [16:0] sum_ab = af[3] ? a_x - b_x : a_x + b_x;
  wire [16:0] c_x = af[7] ? {op_c_q[15], op_c_q} : 17'h00001;
  wire signed [33:0] prod_full = $signed(sum_ab) * $signed(c_x);
  // Top two bits always agree, so the MSB carries nothing
  wire [32:0] prod_keep = af[2] ? 33'h000000000 - prod_full[32:0]
                                : prod_full[32:0];
  // Both legal mixed forms multiply a fraction by an integer, so the
  // product already carries the fraction scale of the result; the mixed
  // bit only labels the form and no shift is applied
  wire [32:0] prod_scaled = product_buffer_q;
  wire [32:0] e_x = af[6] ? {{17{op_e_q[15]}}, op_e_q} : 33'h000000000;
  wire signed [33:0] total = af[4]
    ? $signed({prod_scaled[32], prod_scaled}) - $signed({e_x[32], e_x})
    : $signed({prod_scaled[32], prod_scaled}) + $signed({e_x[32], e_x});
  // Integer and fraction limits share bit patterns on the 16-bit word
  wire over = total > $signed({{17{1'b0}}, 17'h07FFF});
  wire under = total < -$signed({{17{1'b0}}, 17'h08000});
  wire [15:0] clamped = over ? 16'h7FFF : under ? 16'h8000
                      : total[15:0];

  // --------------------------------------------------------------------
  // Sequencer: four quarters per instruction cycle
  // --------------------------------------------------------------------
  wire [5:0] cur_field = slot_field(instr_q, phase_q);
  wire [2:0] cur_src = cur_field[2:0];
  wire [2:0] cur_dst = cur_field[5:3];
  wire slot_live = (state_q == ST_RUN) & ~ctrl_q[`FPA_CTRL_NOP_BIT];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      phase_q <= 2'b00;
      tail_q <= 1'b0;
      pause_q <= 3'h0;
      move_data_q <= `FPA_WORD_RST;
      move_tidx_q <= 7'h00;
      product_buffer_q <= 33'h000000000;
    end
    else
    begin
      // Carry slot 3's load over the end of the instruction cycle
      tail_q <= slot_live & (phase_q == 2'b11);
      case (state_q)
        ST_IDLE:
        begin
          phase_q <= 2'b00;
          if (apb_wr && paddr == `FPA_OFF_INSTR)
          begin
            state_q <= ST_RUN;
            pause_q <= ctrl_q[2:0]; // Pause may ride any instruction
          end
        end
        ST_RUN:
        begin
          phase_q <= phase_q + 2'b01;
          // Each slot samples its source in its own quarter
          move_data_q <= read_source(cur_src);
          move_tidx_q <= instr_q[30:24] ^ {1'b0, cur_field};
          // Operands as they stand before any move of this cycle lands
          if (phase_q == 2'b00)
            product_buffer_q <= prod_keep;
          if (phase_q == 2'b11)
            state_q <= (pause_q != 3'h0) ? ST_PAUSE : ST_IDLE;
        end
        ST_PAUSE:
        begin
          // One whole cycle per remaining count
          phase_q <= phase_q + 2'b01;
          if (phase_q == 2'b11)
          begin
            pause_q <= pause_q - 3'h1;
            if (pause_q == 3'h1)
              state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Move bus loads and arithmetic result
  // --------------------------------------------------------------------
  // A slot loads one quarter after its sample; slot 3's load falls on the
  // first edge of the next cycle, carried there by tail_q
  wire load_now = (slot_live & (phase_q != 2'b00)) | tail_q;
  wire [5:0] prev_field = slot_field(instr_q, phase_q - 2'b01);
  wire [2:0] prev_dst = prev_field[5:3];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_a_q <= `FPA_WORD_RST;
      op_b_q <= `FPA_WORD_RST;
      op_c_q <= `FPA_WORD_RST;
      op_d_q <= `FPA_WORD_RST;
      op_e_q <= `FPA_WORD_RST;
      result_reg_q <= `FPA_WORD_RST;
      sys_bus_out <= `FPA_WORD_RST;
      conflict_q <= 1'b0;
    end
    else
    begin
      // Read clear comes first, so a conflict raised in the same cycle
      // overrides it and is not lost
      if (apb_rd && paddr == `FPA_OFF_STATUS)
        conflict_q <= 1'b0;
      if (apb_wr && paddr == `FPA_OFF_OPA)
        op_a_q <= pwdata[15:0];
      if (apb_wr && paddr == `FPA_OFF_STORE)
        op_d_q <= pwdata[15:0];
      // Destinations load one quarter after their source sample
      if (load_now)
      begin
        case (prev_dst)
          3'd0: op_a_q <= move_data_q;
          3'd1: op_b_q <= move_data_q;
          3'd2: op_c_q <= move_data_q;
          3'd3: op_d_q <= move_data_q;
          3'd4: op_e_q <= move_data_q;
          3'd5: result_reg_q <= move_data_q;
          3'd6:
          begin
            // Load register only legal in slot 1
            if (phase_q == 2'b10)
              sys_bus_out <= move_data_q;
            if (phase_q == 2'b00)
              conflict_q <= 1'b1;
          end
          default: ;
        endcase
      end
      // Slot 1 quarter: automatic D to E copy
      if (slot_live && phase_q == 2'b01)
        op_e_q <= op_d_q;
      // Slot 3 load completes at the next cycle's start
      if (state_q == ST_RUN && phase_q == 2'b11 && cur_dst == 3'd6)
        conflict_q <= 1'b1;
      // Result lands at the three-quarter point
      if (slot_live && phase_q == 2'b10 && af[0])
        result_reg_q <= clamped;
      else if (slot_live && phase_q == 2'b10)
        result_reg_q <= `FPA_WORD_RST;
    end
  end

  // Scratch file writes
  always @(posedge pclk)
  begin
    if (load_now && prev_dst == 3'd7)
      scratch_file[move_tidx_q] <= move_data_q;
  end

  // --------------------------------------------------------------------
  // Sticky range flags; a new error beats a read clear
  // --------------------------------------------------------------------
  wire arith_done = slot_live & (phase_q == 2'b10) & af[0];
  wire st_rd = apb_rd & (paddr == `FPA_OFF_STATUS);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_range_err_q <= 1'b0;
      neg_range_err_q <= 1'b0;
      range_err_q <= 1'b0;
    end
    else
    begin
      pos_range_err_q <= (arith_done & over) | (pos_range_err_q & ~st_rd);
      neg_range_err_q <= (arith_done & under) | (neg_range_err_q & ~st_rd);
      range_err_q <= (arith_done & (over | under))
                   | (range_err_q & ~st_rd);
    end
  end

  // --------------------------------------------------------------------
  // APB writes to instruction and control, and read mux
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_q <= 32'h00000000;
      ctrl_q <= 4'h0;
      bus_store_reg_q <= `FPA_WORD_RST;
    end
    else
    begin
      // Instructions are only taken while idle, so a cycle is never torn
      if (apb_wr && paddr == `FPA_OFF_INSTR && state_q == ST_IDLE)
        instr_q <= pwdata;
      if (apb_wr && paddr == `FPA_OFF_CTRL)
        ctrl_q <= pwdata[3:0];
      bus_store_reg_q <= sys_bus_data;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `FPA_OFF_INSTR: prdata <= instr_q;
        `FPA_OFF_CTRL: prdata <= {28'h0000000, ctrl_q};
        `FPA_OFF_STATUS: prdata <= {16'h0000, range_err_q, pos_range_err_q,
          neg_range_err_q, conflict_q, 2'b00, busy, 6'h00, pause_q};
        `FPA_OFF_RESULT: prdata <= {16'h0000, result_reg_q};
        `FPA_OFF_STORE: prdata <= {16'h0000, bus_store_reg_q};
        `FPA_OFF_LOAD: prdata <= {16'h0000, sys_bus_out};
        `FPA_OFF_OPA: prdata <= {16'h0000, op_a_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // fpa_unit
`default_nettype wire

// >>> fpa_unit_chk.sv
// Port checker for the fixed-point arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module fpa_unit_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy
);
  // ------
  // Helper state
  // ------
  logic [2:0] ctl_q;
  logic [2:0] run_q;
  logic [5:0] cnt_q;
  logic seen_q;
  wire logic wr = psel && penable && pwrite;
  wire logic rd = psel && penable && !pwrite;
  wire logic st = rd && paddr == 12'h008;
  // Pause count is taken at launch; seen_q marks a status read while idle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctl_q <= 3'h0;
      run_q <= 3'h0;
      cnt_q <= 6'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr == 12'h004)
        ctl_q <= pwdata[2:0];
      if (wr && paddr == 12'h000 && !busy)
        run_q <= ctl_q;
      cnt_q <= busy ? cnt_q + 6'h01 : 6'h00;
      seen_q <= busy ? 1'b0 : (st ? 1'b1 : seen_q);
    end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_busy_start: assert property (wr && paddr == 12'h000 && !busy |=> busy)
    else $error("instruction did not start");
  a_busy_length: assert property (!busy && cnt_q != 6'h00 |->
    cnt_q == 6'h04 * (run_q + 6'h01)) else $error("busy length wrong");
  a_cycle_whole: assert property ($rose(busy) |-> busy [*4])
    else $error("instruction cycle cut short");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=>
    $stable(prdata)) else $error("read data moved");
  a_zero_wait: assert property (psel |-> pready && !pslverr)
    else $error("wait state or error");
  a_active_bit: assert property (st |-> prdata[9] == $past(busy))
    else $error("active bit wrong");
  a_range_or: assert property (st |-> prdata[15] == |prdata[14:13])
    else $error("range summary wrong");
  a_flags_clear: assert property (st && seen_q |-> prdata[15:13] == 3'h0)
    else $error("range flags not cleared");
  a_unmapped_zero: assert property (rd && paddr > 12'h018 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  c_launch: cover property (wr && paddr == 12'h000);
  c_status: cover property (st && prdata[15]);
  c_done: cover property ($fell(busy));
endmodule // fpa_unit_chk
bind fpa_unit fpa_unit_chk fpa_unit_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy));
`default_nettype wire

// >>> fpa_bus_model.sv
// Model of the shared system data bus beside the unit
`timescale 1ns/1ps
`default_nettype none
module fpa_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drive,
  input wire logic [15:0] word,
  output logic [15:0] sys_bus_data
);
  logic [15:0] last_q;
  // A released bus shows the inverse of the last word, never a stale copy
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      last_q <= 16'h0000;
    else if (drive)
      last_q <= word;
  assign sys_bus_data = drive ? word : ~last_q;
endmodule // fpa_bus_model
`default_nettype wire

// >>> test_fixed_point_arith_move_unit.sv
// Self-checking testbench of the fixed-point arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module test_fixed_point_arith_move_unit;
  logic pclk, presetn, psel, penable, pwrite, drive;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] word;
  wire logic [31:0] prdata;
  wire logic [15:0] sys_bus_data, sys_bus_out;
  wire logic pready, pslverr, busy;
  int errors, total_checks, cyc;
  fpa_unit fpa_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_bus_data(sys_bus_data), .sys_bus_out(sys_bus_out), .busy(busy));
  fpa_bus_model fpa_bus_model_i (.pclk(pclk), .presetn(presetn),
    .drive(drive), .word(word), .sys_bus_data(sys_bus_data));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ------
  // Shared tasks
  // ------
  task automatic print_verdict;
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; read data is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      errors++;
      $display("CHECK FAILED pready expected 1 seen timeout");
      print_verdict;
    end
  endtask
  // Launch one instruction and count its busy cycles
  task automatic run(input logic [31:0] ctl, ins);
    int i;
    apb(1'b1, 12'h004, ctl);
    apb(1'b1, 12'h000, ins);
    cyc = 0;
    for (i = 0; i < 64; i++)
    begin
      @(posedge pclk);
      if (busy === 1'b1)
        cyc++;
      else if (cyc > 0)
        break;
    end
    if (i == 64)
    begin
      errors++;
      $display("CHECK FAILED busy expected done seen timeout");
      print_verdict;
    end
  endtask
  // Load A, B, C, E then compute; B and C arrive from the system bus
  task automatic arith(input logic [15:0] a, b, c, e, input logic [7:0] op,
    input logic [15:0] r, input logic [2:0] f);
    apb(1'b1, 12'h018, {16'h0, a});
    word <= b;
    drive <= 1'b1;
    run(32'h0, 32'h0000_0E00);
    word <= c;
    run(32'h0, 32'h0000_1600);
    drive <= 1'b0;
    apb(1'b1, 12'h010, {16'h0, e});
    run(32'h0, {24'h0008C0, op});
    apb(1'b0, 12'h00C, 32'h0);
    chk("result", r, rd[15:0]);
    apb(1'b0, 12'h008, 32'h0);
    chk("flags", {12'h0, f, 1'b0}, {12'h0, rd[15:12]});
    apb(1'b0, 12'h008, 32'h0);
    chk("flags clear", 16'h0, {12'h0, rd[15:12]});
  endtask
  // ------
  // Main sequence
  // ------
  initial
  begin
    errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    word = 16'h0;
    drive = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0);
    chk("reset result", 16'h0, rd[15:0]);
    apb(1'b1, 12'h01C, 32'hFFFF);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped", 16'h0, rd[15:0]);
    arith(16'h3, 16'h4, 16'h5, 16'h6, 8'hE1, 16'h29, 3'h0);
    run(32'h8, 32'h0);
    chk("nop cycles", 16'h4, cyc[15:0]);
    apb(1'b0, 12'h00C, 32'h0);
    chk("nop result", 16'h29, rd[15:0]);
    word <= 16'hA5C3;
    drive <= 1'b1;
    // Slot 0 moves the bus into A, slot 1 moves the bus into L
    run(32'h0, 32'h000D_8600);
    drive <= 1'b0;
    chk("bus out", 16'hA5C3, sys_bus_out);
    apb(1'b0, 12'h018, 32'h0);
    chk("bus to A", 16'hA5C3, rd[15:0]);
    apb(1'b0, 12'h00C, 32'h0);
    chk("idle result", 16'h0, rd[15:0]);
    arith(16'h7FFE, 16'h1, 16'h1, 16'h0, 8'hE1, 16'h7FFF, 3'h0);
    arith(16'h7FFF, 16'h1, 16'h1, 16'h0, 8'hE1, 16'h7FFF, 3'h6);
    arith(16'h8000, 16'h1, 16'h1, 16'h0, 8'hE9, 16'h8000, 3'h5);
    arith(16'h8001, 16'h0, 16'h1, 16'h1, 8'hF1, 16'h8000, 3'h0);
    arith(16'hFFFF, 16'h0, 16'h8000, 16'h0, 8'hE5, 16'h8000, 3'h0);
    arith(16'h7FFF, 16'h7FFF, 16'h8000, 16'h0, 8'hE5, 16'h7FFF, 3'h6);
    arith(16'hC000, 16'h0, 16'h3, 16'h0, 8'hE3, 16'h8000, 3'h5);
    arith(16'h2, 16'h1, 16'h2000, 16'h1000, 8'hE3, 16'h7000, 3'h0);
    arith(16'h3, 16'h1, 16'h2000, 16'h0, 8'hE3, 16'h7FFF, 3'h6);
    run(32'h7, 32'h0008_C0E1);
    chk("pause cycles", 16'h20, cyc[15:0]);
    apb(1'b0, 12'h00C, 32'h0);
    chk("pause result", 16'h7FFF, rd[15:0]);
    run(32'h0, 32'hC000_0000);
    chk("plain cycles", 16'h4, cyc[15:0]);
    apb(1'b0, 12'h008, 32'h0);
    chk("conflict", 16'h1, {15'h0, rd[12]});
    print_verdict;
  end
endmodule // test_fixed_point_arith_move_unit
`default_nettype wire
